// file: wia_pkg.sv
package wia_pkg;

  typedef enum logic [3:0] {
    WIA_OP_NONE,
    WIA_OP_WORD_ADD,
    WIA_OP_WORD_SUB,
    WIA_OP_WORD_CMP,
    WIA_OP_BYTE_PLUS_ONE,
    WIA_OP_BYTE_MINUS_ONE,
    WIA_OP_PAIR_PLUS_ONE,
    WIA_OP_PAIR_MINUS_ONE,
    WIA_OP_ROTATE_RIGHT,
    WIA_OP_ROTATE_LEFT,
    WIA_OP_ROTATE_RIGHT_THROUGH_CARRY,
    WIA_OP_ROTATE_LEFT_THROUGH_CARRY
  } wia_op_t;

  localparam int        WIA_WORD_W    = 16;
  localparam int        WIA_BYTE_W    = 8;
  localparam int        WIA_NIB_W     = 4;
  localparam int        WIA_BYTE_MSB  = 7;
  localparam int        WIA_BYTE_LSB  = 0;
  localparam logic      WIA_FLAG_RST  = 1'h0;
  localparam logic [7:0] WIA_BYTE_ONE = 8'h01;
  localparam logic [15:0] WIA_WORD_ONE = 16'h0001;
  localparam logic [3:0] WIA_NIB_ONE  = 4'h1;
  localparam logic [3:0] WIA_NIB_ZERO = 4'h0;

endpackage : wia_pkg

// file: wia_alu.sv
// Functional notes
// - word add: accumulator pair plus immediate word, sum written back
// - word add sets zero flag when the 16-bit sum is zero
// - word add sets carry flag on carry out of bit 15
// - word add, subtract, compare leave nibble-carry undefined; the logic clears it to 0 for all three
// - word subtract: accumulator pair minus immediate word, written back
// - word subtract sets zero flag when the stored difference is zero
// - word subtract and compare set carry on borrow at bit 15
// - word compare subtracts without writing; only the three flags change
// - word compare sets zero flag when the difference is zero
// - byte increment adds one; zero flag from the 8-bit result
// - byte increment sets nibble-carry on carry from bit 3 to 4
// - byte increment and decrement hold the carry flag
// - byte decrement subtracts one; zero flag from the 8-bit result
// - byte decrement sets nibble-carry on borrow from bit 4 to 3
// - pair increment adds one, all flags unchanged
// - pair decrement subtracts one, all flags unchanged
// - rotate right: bit 0 to bit 7 and carry; other flags hold
// - rotate left: bit 7 to bit 0 and carry; other flags hold
// - rotate right through carry: carry to bit 7, bit 0 to carry
// - rotate left through carry: carry to bit 0, bit 7 to carry
`timescale 1ns/1ps
module wia_alu #(
  parameter int WORD_W = wia_pkg::WIA_WORD_W,
  parameter int BYTE_W = wia_pkg::WIA_BYTE_W
) (
  input  wire logic                clk_in,            // core clock, 25 MHz
  input  wire logic                reset_in,          // synchronous, active high
  input  wire logic                issue_in,          // one-cycle operation strobe
  input  wire wia_pkg::wia_op_t    op_in,             // operation select
  input  wire logic [WORD_W-1:0]   word_accumulator_in, // accumulator pair
  input  wire logic [WORD_W-1:0]   imm_word_in,       // immediate word
  input  wire logic [BYTE_W-1:0]   byte_operand_in,   // byte register or memory byte
  input  wire logic [WORD_W-1:0]   register_pair_in,  // selected register pair
  input  wire logic [BYTE_W-1:0]   byte_accumulator_in, // byte accumulator
  input  wire logic                zero_flag_in,      // current zero flag
  input  wire logic                nibble_carry_flag_in, // current nibble-carry flag
  input  wire logic                carry_flag_in,     // current carry flag
  output logic                     done_out,          // result valid pulse
  output logic                     word_we_out,       // write word result to accumulator pair
  output logic [WORD_W-1:0]        word_result_out,   // word result
  output logic                     byte_we_out,       // write byte result
  output logic [BYTE_W-1:0]        byte_result_out,   // byte result
  output logic                     pair_we_out,       // write register pair
  output logic [WORD_W-1:0]        pair_result_out,   // register pair result
  output logic                     acc_we_out,        // write byte accumulator
  output logic [BYTE_W-1:0]        acc_result_out,    // rotated accumulator
  output logic                     zero_flag_out,     // updated zero flag
  output logic                     nibble_carry_flag_out, // updated nibble-carry flag
  output logic                     carry_flag_out     // updated carry flag
);

  ////////////////////////////////////////////////////////////////////////////
  // combinational datapath

  logic [WORD_W:0]   add_ext;
  logic [WORD_W:0]   sub_ext;
  logic [BYTE_W-1:0] inc_b;
  logic [BYTE_W-1:0] dec_b;
  logic [WORD_W-1:0] word_d;
  logic [BYTE_W-1:0] byte_d;
  logic [WORD_W-1:0] pair_d;
  logic [BYTE_W-1:0] acc_d;
  logic              word_we_d;
  logic              byte_we_d;
  logic              pair_we_d;
  logic              acc_we_d;
  logic              zero_d;
  logic              nib_d;
  logic              carry_d;

  function automatic logic is_zero_word(input logic [WORD_W-1:0] v);
    is_zero_word = (v == '0);
  endfunction : is_zero_word

  function automatic logic is_zero_byte(input logic [BYTE_W-1:0] v);
    is_zero_byte = (v == '0);
  endfunction : is_zero_byte

  assign add_ext = {1'b0, word_accumulator_in} + {1'b0, imm_word_in};
  assign sub_ext = {1'b0, word_accumulator_in} - {1'b0, imm_word_in};
  assign inc_b   = byte_operand_in + BYTE_W'(wia_pkg::WIA_BYTE_ONE);
  assign dec_b   = byte_operand_in - BYTE_W'(wia_pkg::WIA_BYTE_ONE);

  // increment carries into bit 4 when the low nibble of the result wrapped
  function automatic logic nib_carry_up(input logic [BYTE_W-1:0] v);
    nib_carry_up = (v[wia_pkg::WIA_NIB_W-1:0] == wia_pkg::WIA_NIB_ZERO);
  endfunction : nib_carry_up

  // decrement borrows from bit 4 when the low nibble of the operand was zero
  function automatic logic nib_borrow_down(input logic [BYTE_W-1:0] v);
    nib_borrow_down = (v[wia_pkg::WIA_NIB_W-1:0] == wia_pkg::WIA_NIB_ZERO);
  endfunction : nib_borrow_down

  ////////////////////////////////////////////////////////////////////////////
  // rotate bodies: every bit but the end bit takes its neighbour

  logic [BYTE_W-2:0] ror_body;
  logic [BYTE_W-2:0] rol_body;

  for (genvar i = 0; i < BYTE_W - 1; i++) begin : g_rot_body
    assign ror_body[i] = byte_accumulator_in[i+1];
    assign rol_body[i] = byte_accumulator_in[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // word path: add and subtract write back, compare only sets flags

  always_comb begin
    word_d    = word_accumulator_in;
    word_we_d = 1'b0;
    unique case (op_in)
      wia_pkg::WIA_OP_WORD_ADD: begin
        word_d    = add_ext[WORD_W-1:0];
        word_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_WORD_SUB: begin
        word_d    = sub_ext[WORD_W-1:0];
        word_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_WORD_CMP: begin
        // the difference is discarded: no write enable
        word_d    = sub_ext[WORD_W-1:0];
        word_we_d = 1'b0;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte and pair paths: step by one and write back

  always_comb begin
    byte_d    = byte_operand_in;
    byte_we_d = 1'b0;
    unique case (op_in)
      wia_pkg::WIA_OP_BYTE_PLUS_ONE: begin
        byte_d    = inc_b;
        byte_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_BYTE_MINUS_ONE: begin
        byte_d    = dec_b;
        byte_we_d = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    pair_d    = register_pair_in;
    pair_we_d = 1'b0;
    unique case (op_in)
      wia_pkg::WIA_OP_PAIR_PLUS_ONE: begin
        pair_d    = register_pair_in + WORD_W'(wia_pkg::WIA_WORD_ONE);
        pair_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_PAIR_MINUS_ONE: begin
        pair_d    = register_pair_in - WORD_W'(wia_pkg::WIA_WORD_ONE);
        pair_we_d = 1'b1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator path: the four single-bit rotates

  always_comb begin
    acc_d    = byte_accumulator_in;
    acc_we_d = 1'b0;
    unique case (op_in)
      wia_pkg::WIA_OP_ROTATE_RIGHT: begin
        acc_d    = {byte_accumulator_in[wia_pkg::WIA_BYTE_LSB], ror_body};
        acc_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_ROTATE_LEFT: begin
        acc_d    = {rol_body, byte_accumulator_in[BYTE_W-1]};
        acc_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        acc_d    = {carry_flag_in, ror_body};
        acc_we_d = 1'b1;
      end
      wia_pkg::WIA_OP_ROTATE_LEFT_THROUGH_CARRY: begin
        acc_d    = {rol_body, carry_flag_in};
        acc_we_d = 1'b1;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag paths: each flag holds its input unless the operation defines it, and word ops clear nibble-carry

  always_comb begin
    zero_d = zero_flag_in;
    unique case (op_in)
      wia_pkg::WIA_OP_WORD_ADD: begin
        zero_d = is_zero_word(add_ext[WORD_W-1:0]);
      end
      wia_pkg::WIA_OP_WORD_SUB: begin
        zero_d = is_zero_word(sub_ext[WORD_W-1:0]);
      end
      wia_pkg::WIA_OP_WORD_CMP: begin
        zero_d = is_zero_word(sub_ext[WORD_W-1:0]);
      end
      wia_pkg::WIA_OP_BYTE_PLUS_ONE: begin
        zero_d = is_zero_byte(inc_b);
      end
      wia_pkg::WIA_OP_BYTE_MINUS_ONE: begin
        zero_d = is_zero_byte(dec_b);
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    nib_d = nibble_carry_flag_in;
    unique case (op_in)
      wia_pkg::WIA_OP_WORD_ADD, wia_pkg::WIA_OP_WORD_SUB, wia_pkg::WIA_OP_WORD_CMP: begin
        // left undefined; driven low so the flag never goes unknown
        nib_d = 1'b0;
      end
      wia_pkg::WIA_OP_BYTE_PLUS_ONE: begin
        nib_d = nib_carry_up(inc_b);
      end
      wia_pkg::WIA_OP_BYTE_MINUS_ONE: begin
        nib_d = nib_borrow_down(byte_operand_in);
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    carry_d = carry_flag_in;
    unique case (op_in)
      wia_pkg::WIA_OP_WORD_ADD: begin
        carry_d = add_ext[WORD_W];
      end
      wia_pkg::WIA_OP_WORD_SUB, wia_pkg::WIA_OP_WORD_CMP: begin
        carry_d = sub_ext[WORD_W];
      end
      wia_pkg::WIA_OP_BYTE_PLUS_ONE, wia_pkg::WIA_OP_BYTE_MINUS_ONE: begin
        carry_d = carry_flag_in;
      end
      wia_pkg::WIA_OP_ROTATE_RIGHT, wia_pkg::WIA_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        carry_d = byte_accumulator_in[wia_pkg::WIA_BYTE_LSB];
      end
      wia_pkg::WIA_OP_ROTATE_LEFT, wia_pkg::WIA_OP_ROTATE_LEFT_THROUGH_CARRY: begin
        carry_d = byte_accumulator_in[BYTE_W-1];
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers: enables pulse for one cycle, results and flags stand

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= issue_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      word_we_out <= 1'b0;
    end else begin
      word_we_out <= issue_in & word_we_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      byte_we_out <= 1'b0;
    end else begin
      byte_we_out <= issue_in & byte_we_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pair_we_out <= 1'b0;
    end else begin
      pair_we_out <= issue_in & pair_we_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_we_out <= 1'b0;
    end else begin
      acc_we_out <= issue_in & acc_we_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      word_result_out <= '0;
    end else if (issue_in) begin
      word_result_out <= word_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      byte_result_out <= '0;
    end else if (issue_in) begin
      byte_result_out <= byte_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pair_result_out <= '0;
    end else if (issue_in) begin
      pair_result_out <= pair_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_result_out <= '0;
    end else if (issue_in) begin
      acc_result_out <= acc_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      zero_flag_out <= wia_pkg::WIA_FLAG_RST;
    end else if (issue_in) begin
      zero_flag_out <= zero_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      nibble_carry_flag_out <= wia_pkg::WIA_FLAG_RST;
    end else if (issue_in) begin
      nibble_carry_flag_out <= nib_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carry_flag_out <= wia_pkg::WIA_FLAG_RST;
    end else if (issue_in) begin
      carry_flag_out <= carry_d;
    end
  end

endmodule : wia_alu

// file: wia_alu_properties.sv
`timescale 1ns/1ps
module wia_alu_chk #(
  parameter int WORD_W = 16,
  parameter int BYTE_W = 8
) (
  input wire logic              clk_in, reset_in, issue_in,
  input wire wia_pkg::wia_op_t  op_in,
  input wire logic [WORD_W-1:0] word_accumulator_in, imm_word_in, register_pair_in,
  input wire logic [BYTE_W-1:0] byte_operand_in, byte_accumulator_in,
  input wire logic              zero_flag_in, nibble_carry_flag_in, carry_flag_in,
  input wire logic              done_out, word_we_out, byte_we_out, pair_we_out, acc_we_out,
  input wire logic [WORD_W-1:0] word_result_out, pair_result_out,
  input wire logic [BYTE_W-1:0] byte_result_out, acc_result_out,
  input wire logic              zero_flag_out, nibble_carry_flag_out, carry_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_op(wia_pkg::wia_op_t o);
    issue_in && op_in == o;
  endsequence
  AST_ADD: assert property (s_op(wia_pkg::WIA_OP_WORD_ADD) |=> done_out && word_we_out
    && {carry_flag_out, word_result_out} == $past({1'b0, word_accumulator_in} + imm_word_in))
    else $error("word add result or carry wrong");
  AST_WORD_ZERO: assert property ((s_op(wia_pkg::WIA_OP_WORD_ADD) or s_op(wia_pkg::WIA_OP_WORD_SUB))
    |=> zero_flag_out == (word_result_out == '0)) else $error("word zero flag wrong");
  AST_SUB: assert property (s_op(wia_pkg::WIA_OP_WORD_SUB) |=> word_we_out
    && {carry_flag_out, word_result_out} == $past({1'b0, word_accumulator_in} - {1'b0, imm_word_in}))
    else $error("word subtract result or borrow wrong");
  AST_CMP: assert property (s_op(wia_pkg::WIA_OP_WORD_CMP) |=> {word_we_out, byte_we_out, pair_we_out, acc_we_out} == 4'h0
    && zero_flag_out == $past(word_accumulator_in == imm_word_in)
    && carry_flag_out == $past(word_accumulator_in < imm_word_in)) else $error("word compare wrong");
  AST_BYTE_CY: assert property ((s_op(wia_pkg::WIA_OP_BYTE_PLUS_ONE) or s_op(wia_pkg::WIA_OP_BYTE_MINUS_ONE))
    |=> byte_we_out && carry_flag_out == $past(carry_flag_in)) else $error("byte step changed carry");
  AST_INC: assert property (s_op(wia_pkg::WIA_OP_BYTE_PLUS_ONE) |=> byte_result_out == $past(byte_operand_in + 8'h01)
    && nibble_carry_flag_out == $past(byte_operand_in[3:0] == 4'hf)
    && zero_flag_out == (byte_result_out == '0)) else $error("byte increment wrong");
  AST_DEC: assert property (s_op(wia_pkg::WIA_OP_BYTE_MINUS_ONE) |=> byte_result_out == $past(byte_operand_in - 8'h01)
    && nibble_carry_flag_out == $past(byte_operand_in[3:0] == 4'h0)
    && zero_flag_out == (byte_result_out == '0)) else $error("byte decrement wrong");
  AST_PAIR: assert property ((s_op(wia_pkg::WIA_OP_PAIR_PLUS_ONE) or s_op(wia_pkg::WIA_OP_PAIR_MINUS_ONE))
    |=> pair_we_out && pair_result_out == $past(op_in == wia_pkg::WIA_OP_PAIR_PLUS_ONE
    ? register_pair_in + 16'h0001 : register_pair_in - 16'h0001)
    && {zero_flag_out, nibble_carry_flag_out, carry_flag_out}
    == $past({zero_flag_in, nibble_carry_flag_in, carry_flag_in})) else $error("pair step wrong");
  AST_ROR: assert property (s_op(wia_pkg::WIA_OP_ROTATE_RIGHT) |=> acc_we_out && {acc_result_out, carry_flag_out}
    == $past({byte_accumulator_in[0], byte_accumulator_in}) && {zero_flag_out, nibble_carry_flag_out}
    == $past({zero_flag_in, nibble_carry_flag_in})) else $error("rotate right wrong");
  AST_ROL: assert property (s_op(wia_pkg::WIA_OP_ROTATE_LEFT) |=> {carry_flag_out, acc_result_out}
    == $past({byte_accumulator_in, byte_accumulator_in[BYTE_W-1]})) else $error("rotate left wrong");
  AST_ROTATE_RIGHT_THROUGH_CARRY: assert property (s_op(wia_pkg::WIA_OP_ROTATE_RIGHT_THROUGH_CARRY) |=> {acc_result_out,
    carry_flag_out} == $past({carry_flag_in, byte_accumulator_in})) else $error("rotate right carry wrong");
  AST_ROTATE_LEFT_THROUGH_CARRY: assert property (s_op(wia_pkg::WIA_OP_ROTATE_LEFT_THROUGH_CARRY) |=> {carry_flag_out,
    acc_result_out} == $past({byte_accumulator_in, carry_flag_in})) else $error("rotate left carry wrong");
  AST_ROT_HOLD: assert property ((s_op(wia_pkg::WIA_OP_ROTATE_LEFT)
    or s_op(wia_pkg::WIA_OP_ROTATE_RIGHT_THROUGH_CARRY)
    or s_op(wia_pkg::WIA_OP_ROTATE_LEFT_THROUGH_CARRY))
    |=> acc_we_out && {zero_flag_out, nibble_carry_flag_out} == $past({zero_flag_in, nibble_carry_flag_in}))
    else $error("rotate changed zero or nibble-carry");
endmodule : wia_alu_chk
bind wia_alu wia_alu_chk #(.WORD_W(WORD_W), .BYTE_W(BYTE_W)) u_chk (.*);

// file: wia_seq_model.sv
`timescale 1ns/1ps
module wia_seq_model (
  input  wire logic       clk_in,    // core clock
  input  wire logic       reset_in,  // synchronous, active high
  input  wire logic       done_in,   // alu result valid
  input  wire logic [2:0] flags_in,  // zero, nibble-carry, carry from the alu
  input  wire logic       load_in,   // preset the flag register
  input  wire logic [2:0] preset_in, // preset value
  output logic      [2:0] flags_out  // flag register fed back to the alu
);
  // flags move only on done or a preset load, so the next issue sees the written-back state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flags_out <= 3'h0;
    end else if (load_in) begin
      flags_out <= preset_in;
    end else if (done_in) begin
      flags_out <= flags_in;
    end
  end
endmodule : wia_seq_model

// file: tb_word_arith_incdec_rotate_alu.sv
`timescale 1ns/1ps
module tb_word_arith_incdec_rotate_alu;
  logic clk_in = 1'b0, reset_in = 1'b1, issue_in = 1'b0, load = 1'b0, dn, wwe, bwe, pwe, awe;
  wia_pkg::wia_op_t op = wia_pkg::WIA_OP_NONE;
  logic [15:0] a16 = 16'h0000, b16 = 16'h0000, wres, pres;
  logic [7:0]  b8 = 8'h00, bres, ares;
  logic [2:0]  pre = 3'h0, fl, fo;
  int          err_total = 0, compares = 0, cycles = 0;
  always #20 clk_in = ~clk_in;
  wia_alu u_dut (.clk_in(clk_in), .reset_in(reset_in), .issue_in(issue_in), .op_in(op),
    .word_accumulator_in(a16), .imm_word_in(b16), .byte_operand_in(b8), .register_pair_in(a16),
    .byte_accumulator_in(b8), .zero_flag_in(fl[2]), .nibble_carry_flag_in(fl[1]),
    .carry_flag_in(fl[0]), .done_out(dn), .word_we_out(wwe), .word_result_out(wres),
    .byte_we_out(bwe), .byte_result_out(bres), .pair_we_out(pwe), .pair_result_out(pres),
    .acc_we_out(awe), .acc_result_out(ares), .zero_flag_out(fo[2]),
    .nibble_carry_flag_out(fo[1]), .carry_flag_out(fo[0]));
  wia_seq_model u_seq (.clk_in(clk_in), .reset_in(reset_in), .done_in(dn), .flags_in(fo),
    .load_in(load), .preset_in(pre), .flags_out(fl));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input wia_pkg::wia_op_t o, input logic [15:0] a, b, input logic [7:0] c);
    @(posedge clk_in); #1;
    op = o; a16 = a; b16 = b; b8 = c; issue_in = 1'b1;
    @(posedge clk_in); #1;
    issue_in = 1'b0;
    chk(dn, 1'b1);
  endtask : run
  task automatic preset(input logic [2:0] f);
    @(posedge clk_in); #1;
    pre = f; load = 1'b1;
    @(posedge clk_in); #1;
    load = 1'b0;
  endtask : preset
  task automatic t_word;
    run(wia_pkg::WIA_OP_WORD_ADD, 16'hffff, 16'h0001, 8'h00);
    chk({wwe, wres, fo[2], fo[0]}, {1'b1, 16'h0000, 2'h3});
    run(wia_pkg::WIA_OP_WORD_ADD, 16'h1234, 16'h0001, 8'h00);
    chk({wwe, wres, fo[2], fo[0]}, {1'b1, 16'h1235, 2'h0});
    run(wia_pkg::WIA_OP_WORD_SUB, 16'h0005, 16'h0006, 8'h00);
    chk({wwe, wres, fo[2], fo[0]}, {1'b1, 16'hffff, 2'h1});
    run(wia_pkg::WIA_OP_WORD_SUB, 16'h1234, 16'h1234, 8'h00);
    chk({wwe, wres, fo[2], fo[0]}, {1'b1, 16'h0000, 2'h2});
    run(wia_pkg::WIA_OP_WORD_CMP, 16'h0001, 16'h0002, 8'h00);
    chk({wwe, bwe, pwe, awe, fo[2], fo[0]}, 6'h01);
    run(wia_pkg::WIA_OP_WORD_CMP, 16'h8000, 16'h8000, 8'h00);
    chk({wwe, fo[2], fo[0]}, 3'h2);
  endtask : t_word
  task automatic t_byte;
    preset(3'h1);
    run(wia_pkg::WIA_OP_BYTE_PLUS_ONE, 16'h0000, 16'h0000, 8'h0f);
    chk({bwe, bres, fo}, {1'b1, 8'h10, 3'h3});
    run(wia_pkg::WIA_OP_BYTE_PLUS_ONE, 16'h0000, 16'h0000, 8'hff);
    chk({bwe, bres, fo}, {1'b1, 8'h00, 3'h7});
    run(wia_pkg::WIA_OP_BYTE_MINUS_ONE, 16'h0000, 16'h0000, 8'h10);
    chk({bwe, bres, fo}, {1'b1, 8'h0f, 3'h3});
    run(wia_pkg::WIA_OP_BYTE_MINUS_ONE, 16'h0000, 16'h0000, 8'h01);
    chk({bwe, bres, fo}, {1'b1, 8'h00, 3'h5});
  endtask : t_byte
  task automatic t_pair;
    preset(3'h7);
    run(wia_pkg::WIA_OP_PAIR_PLUS_ONE, 16'hffff, 16'h0000, 8'h00);
    chk({pwe, pres}, 17'h10000);
    chk(fo, 3'h7);
    preset(3'h0);
    run(wia_pkg::WIA_OP_PAIR_MINUS_ONE, 16'h0000, 16'h0000, 8'h00);
    chk({pwe, pres, fo}, {1'b1, 16'hffff, 3'h0});
  endtask : t_pair
  task automatic t_rot;
    preset(3'h6);
    run(wia_pkg::WIA_OP_ROTATE_RIGHT, 16'h0000, 16'h0000, 8'h81);
    chk({awe, ares, fo}, 12'he07);
    run(wia_pkg::WIA_OP_ROTATE_LEFT, 16'h0000, 16'h0000, 8'h40);
    chk({awe, ares, fo}, 12'hc06);
    run(wia_pkg::WIA_OP_ROTATE_RIGHT_THROUGH_CARRY, 16'h0000, 16'h0000, 8'h03);
    chk({awe, ares, fo}, 12'h80f);
    run(wia_pkg::WIA_OP_ROTATE_LEFT_THROUGH_CARRY, 16'h0000, 16'h0000, 8'h40);
    chk({awe, ares, fo}, 12'hc0e);
  endtask : t_rot
  task automatic t_reset;
    run(wia_pkg::WIA_OP_WORD_ADD, 16'hffff, 16'h0002, 8'h5a);
    chk({wwe, wres, fo[2], fo[0]}, {1'b1, 16'h0001, 2'h1});
    @(posedge clk_in); #1;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk({dn, wwe, bwe, pwe, awe, fo}, 20'h00000);
    chk(wres, 20'h00000);
    chk(pres, 20'h00000);
    chk({bres, ares}, 20'h00000);
    reset_in = 1'b0;
    preset(3'h5);
    run(wia_pkg::WIA_OP_NONE, 16'h0000, 16'h0000, 8'h00);
    chk({wwe, bwe, pwe, awe, fo}, 20'h00005);
  endtask : t_reset
  task automatic complete_run;
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 reset_in = 1'b0;
    t_word;
    t_byte;
    t_pair;
    t_rot;
    t_reset;
    complete_run;
  end
endmodule : tb_word_arith_incdec_rotate_alu
